// ---- src/i2c_watch_top.sv ----
// two-wire bus support: interrupt enables, bus watchdog and function clock divider
`timescale 1ns/1ps
module i2c_watch_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address channel
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus lines as seen from the pins
  input wire logic scl_in,
  input wire logic sda_in,
  // one-cycle event pulses from the master, target and snoop engines
  input wire logic [31:0] source_events,
  // function clock tick for the master timing and target engines
  output logic function_tick,
  // watchdog view of the bus
  output logic bus_busy,
  // level interrupt
  output logic irq
);
  import i2c_watch_pkg::*;

  // ---------------------------------------------------------------- state
  logic [31:0] enable_q; // interrupt_enable_set contents
  logic [31:0] flag_q; // sticky event flags
  logic [11:0] limit_field_q; // limit_interval_field
  logic [15:0] divide_value_q; // divide_value
  logic gap_check_on_q; // event-gap check running
  logic low_check_on_q; // clock-low check running

  // pin synchronisers: three stages, level taken when stages two and three agree
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_level_q; // filtered clock line
  logic sda_level_q; // filtered data line

  // write channel holding registers
  logic aw_held_q; // write address taken, waiting for data
  logic w_held_q; // write data taken, waiting for address
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // internal pulses
  logic tick_raw; // divider output
  logic busy_raw; // watchdog busy flag
  logic gap_hit; // event gap over limit
  logic low_hit; // clock low over limit
  logic do_write; // both halves of a write present this cycle
  logic do_read; // read address taken this cycle
  logic flag_read_clear; // read address of the sticky flags taken this cycle
  logic [31:0] write_mask; // strobe-expanded write data
  logic [31:0] bit_mask; // strobe-expanded byte lanes
  logic [31:0] new_events; // all events raised this cycle

  // expand byte strobes to a bit mask; used for data and for lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // true for any offset the slave answers
  function automatic logic is_mapped(input logic [11:0] addr);
    case (addr)
      OFF_WATCH_CTRL, OFF_FLAG_STATUS, OFF_ENABLE_SET, OFF_ENABLE_CLEAR,
      OFF_WATCH_LIMIT, OFF_CLOCK_DIVIDER, OFF_FLAG_VIEW: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // ---------------------------------------------------------------- pins
  // the first stage is read only by the second; filtering looks at two and three
  // agreement of two stages rejects a one-cycle glitch at the price of a clock of delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 3'b111;
      sda_sync_q <= 3'b111;
      scl_level_q <= 1'b1; // idle bus floats high
      sda_level_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_level_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_level_q <= sda_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------- engines
  // the divided tick paces the watchdog and is handed out for bus timing
  function_clock_divider u_divider (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divide_value(divide_value_q),
    .function_tick(tick_raw)
  );

  bus_event_watchdog u_watchdog (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_level(scl_level_q),
    .sda_level(sda_level_q),
    .function_tick(tick_raw),
    .limit_interval_field(limit_field_q),
    .gap_check_on(gap_check_on_q),
    .low_check_on(low_check_on_q),
    .bus_busy(busy_raw),
    .bus_event_gap_hit(gap_hit),
    .clock_low_limit_hit(low_hit)
  );

  // retime engine outputs so every top output leaves a flip-flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      function_tick <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      function_tick <= tick_raw;
      bus_busy <= busy_raw;
    end
  end

  // ---------------------------------------------------------------- write path
  // address and data are accepted independently; the write happens once both are held
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign bit_mask = lane_mask(w_strb_q);
  assign write_mask = w_data_q & bit_mask;

  // write address channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0; // one write under way at a time
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response: unmapped offsets answer with a slave error
  // bvalid holds both readies low, so a second write cannot slip in under the answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- registers
  // enables: set register ORs ones in, clear register knocks ones out;
  // zeros in either leave the enable alone
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 32'h0000_0000;
    end else if (do_write && aw_addr_q == OFF_ENABLE_SET) begin
      enable_q <= enable_q | (write_mask & DEFINED_BITS);
    end else if (do_write && aw_addr_q == OFF_ENABLE_CLEAR) begin
      // each defined clear bit maps onto the same enable position;
      // reserved positions are ignored, software should write them as zero
      enable_q <= enable_q & ~(write_mask & DEFINED_BITS);
    end
  end

  // watchdog checks; software stops both before changing the limit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_check_on_q <= 1'b0;
      low_check_on_q <= 1'b0;
    end else if (do_write && aw_addr_q == OFF_WATCH_CTRL && w_strb_q[0]) begin
      gap_check_on_q <= w_data_q[BIT_GAP_CHECK_ON];
      low_check_on_q <= w_data_q[BIT_LOW_CHECK_ON];
    end
  end

  // limit field; the low nibble has no storage and always reads ones
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_field_q <= LIMIT_FIELD_RESET;
    end else if (do_write && aw_addr_q == OFF_WATCH_LIMIT) begin
      // a live change is taken as written; counters compare against the new value at once
      // hazard: a shorter limit written below the running count is passed by, and fires only after the count wraps, hence the stop-first rule
      limit_field_q <= (limit_field_q & ~bit_mask[LIMIT_MSB:LIMIT_LSB])
        | write_mask[LIMIT_MSB:LIMIT_LSB];
    end
  end

  // divider value, byte lanes honoured
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divide_value_q <= DIVIDE_VALUE_RESET;
    end else if (do_write && aw_addr_q == OFF_CLOCK_DIVIDER) begin
      divide_value_q <= (divide_value_q & ~bit_mask[15:0]) | write_mask[15:0];
    end
  end

  // ---------------------------------------------------------------- flags
  // sticky flags: engine pulses and watchdog hits set them, a read of the
  // flag register clears them; a set in the same cycle as that read wins
  // otherwise a hit landing on the clearing read would be lost without a trace
  always_comb begin
    new_events = source_events & DEFINED_BITS;
    new_events[BIT_EVENT_GAP] = gap_hit;
    new_events[BIT_CLOCK_LOW] = low_hit;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 32'h0000_0000;
    end else if (flag_read_clear) begin
      flag_q <= new_events;
    end else begin
      flag_q <= flag_q | new_events;
    end
  end

  // one level interrupt while any enabled flag is set
  // registered, so the pin never glitches while flags and enables change together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & enable_q);
    end
  end

  // ---------------------------------------------------------------- read path
  // one read at a time: arready drops on acceptance and returns after rdata is taken
  // the flag register clears on read, so rdata captures it at the very edge of the clear
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign flag_read_clear = do_read && s_axi_araddr == OFF_FLAG_STATUS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_WATCH_CTRL: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rdata[BIT_GAP_CHECK_ON] <= gap_check_on_q;
          s_axi_rdata[BIT_LOW_CHECK_ON] <= low_check_on_q;
        end
        OFF_FLAG_STATUS: begin
          s_axi_rdata <= flag_q;
        end
        OFF_ENABLE_SET: begin
          s_axi_rdata <= enable_q;
        end
        OFF_WATCH_LIMIT: begin
          s_axi_rdata <= {16'h0000, limit_field_q, LIMIT_LOW_NIBBLE};
        end
        OFF_CLOCK_DIVIDER: begin
          s_axi_rdata <= {16'h0000, divide_value_q};
        end
        OFF_FLAG_VIEW: begin
          s_axi_rdata <= flag_q & enable_q;
        end
        default: begin
          // the clear register keeps nothing to show, so it reads as zero
          s_axi_rdata <= 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : i2c_watch_top

// ---- src/i2c_watch_pkg.sv ----
// constants shared by the two-wire support block: register map, field layout, reset values
package i2c_watch_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 12; // byte address bits decoded by the slave
  localparam int unsigned DATA_W = 32; // register data width

  // register byte offsets
  localparam logic [11:0] OFF_WATCH_CTRL = 12'h800; // check enables for the watchdog
  localparam logic [11:0] OFF_FLAG_STATUS = 12'h804; // sticky event flags, cleared by read
  localparam logic [11:0] OFF_ENABLE_SET = 12'h808; // interrupt_enable_set, write one to enable
  localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h80c; // interrupt_enable_clear, write-only
  localparam logic [11:0] OFF_WATCH_LIMIT = 12'h810; // bus_watch_limit
  localparam logic [11:0] OFF_CLOCK_DIVIDER = 12'h814; // function_clock_divider
  localparam logic [11:0] OFF_FLAG_VIEW = 12'h818; // masked_flag_view

  // defined enable / flag bit positions
  localparam int unsigned BIT_MASTER_WAITING = 0;
  localparam int unsigned BIT_ARBITRATION_LOST = 4;
  localparam int unsigned BIT_START_STOP_ERROR = 6;
  localparam int unsigned BIT_TARGET_WAITING = 8;
  localparam int unsigned BIT_TARGET_NOT_HOLDING = 11;
  localparam int unsigned BIT_TARGET_DESELECT = 15;
  localparam int unsigned BIT_SNOOP_READY = 16;
  localparam int unsigned BIT_SNOOP_OVERRUN = 17;
  localparam int unsigned BIT_SNOOP_IDLE = 19;
  localparam int unsigned BIT_EVENT_GAP = 24;
  localparam int unsigned BIT_CLOCK_LOW = 25;

  // every implemented bit of the enable, flag and clear layouts
  localparam logic [31:0] DEFINED_BITS = 32'h030b_8951;

  // watchdog control bits
  localparam int unsigned BIT_GAP_CHECK_ON = 0;
  localparam int unsigned BIT_LOW_CHECK_ON = 1;

  // limit register layout
  localparam int unsigned LIMIT_LSB = 4;
  localparam int unsigned LIMIT_MSB = 15;
  localparam logic [3:0] LIMIT_LOW_NIBBLE = 4'hf; // hard-wired low bits
  localparam logic [11:0] LIMIT_FIELD_RESET = 12'hfff; // largest limit after reset

  // divider layout
  localparam logic [15:0] DIVIDE_VALUE_RESET = 16'h0000; // divide by one after reset

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : i2c_watch_pkg

// ---- src/function_clock_divider.sv ----
// divider that turns the interface source clock into function clock ticks
`timescale 1ns/1ps
module function_clock_divider (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] divide_value,
  output logic function_tick
);
  import i2c_watch_pkg::*;

  logic [15:0] count_q; // source clocks since last tick

  // one tick every (divide_value + 1) source clocks; a new value takes effect
  // at once: the count runs up to it, or wraps on the next clock if already past it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      function_tick <= 1'b0;
    end else if (count_q >= divide_value) begin
      count_q <= 16'h0000;
      function_tick <= 1'b1;
    end else begin
      count_q <= count_q + 16'h0001;
      function_tick <= 1'b0;
    end
  end

endmodule : function_clock_divider

// ---- src/bus_event_watchdog.sv ----
// bus watchdog: event-gap and clock-low checks timed in function clock ticks
`timescale 1ns/1ps
module bus_event_watchdog (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_level,
  input wire logic sda_level,
  input wire logic function_tick,
  input wire logic [11:0] limit_interval_field,
  input wire logic gap_check_on,
  input wire logic low_check_on,
  output logic bus_busy,
  output logic bus_event_gap_hit,
  output logic clock_low_limit_hit
);
  import i2c_watch_pkg::*;

  logic scl_prev_q; // line levels one clock ago
  logic sda_prev_q;
  logic [15:0] gap_count_q; // ticks since last bus event
  logic [15:0] low_count_q; // ticks with clock held low
  logic gap_done_q; // gap already reported for this interval
  logic low_done_q; // low time already reported for this stretch
  logic start_seen, stop_seen, scl_rise, scl_fall, any_event;
  logic [15:0] limit_last; // tick count at which the limit is reached, minus one

  assign start_seen = scl_level && scl_prev_q && sda_prev_q && !sda_level;
  assign stop_seen = scl_level && scl_prev_q && !sda_prev_q && sda_level;
  assign scl_rise = scl_level && !scl_prev_q;
  assign scl_fall = !scl_level && scl_prev_q;
  assign any_event = start_seen || stop_seen || scl_rise || scl_fall;
  // low nibble is always ones, so the limit is (field + 1) * 16 ticks
  assign limit_last = {limit_interval_field, LIMIT_LOW_NIBBLE};

  // edge history and bus busy tracking between start and stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      scl_prev_q <= scl_level;
      sda_prev_q <= sda_level;
      if (start_seen) begin
        bus_busy <= 1'b1;
      end else if (stop_seen) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // gap between successive events, only while the bus is busy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_count_q <= 16'h0000;
      gap_done_q <= 1'b0;
      bus_event_gap_hit <= 1'b0;
    end else begin
      bus_event_gap_hit <= 1'b0;
      if (any_event || !bus_busy || !gap_check_on) begin
        gap_count_q <= 16'h0000; // restart on every event
        gap_done_q <= 1'b0;
      end else if (function_tick && !gap_done_q) begin
        if (gap_count_q == limit_last) begin
          bus_event_gap_hit <= 1'b1;
          gap_done_q <= 1'b1; // one report per overlong gap
        end else begin
          gap_count_q <= gap_count_q + 16'h0001;
        end
      end
    end
  end

  // time the clock line stays low, only while the bus is busy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_count_q <= 16'h0000;
      low_done_q <= 1'b0;
      clock_low_limit_hit <= 1'b0;
    end else begin
      clock_low_limit_hit <= 1'b0;
      if (scl_level || !bus_busy || !low_check_on) begin
        low_count_q <= 16'h0000; // clock high ends the stretch
        low_done_q <= 1'b0;
      end else if (function_tick && !low_done_q) begin
        if (low_count_q == limit_last) begin
          clock_low_limit_hit <= 1'b1;
          low_done_q <= 1'b1;
        end else begin
          low_count_q <= low_count_q + 16'h0001;
        end
      end
    end
  end

endmodule : bus_event_watchdog

// ---- tb/i2c_bus_agent.sv ----
// model of another master on the two bus lines
`timescale 1ns/1ps
module i2c_bus_agent (
  output logic scl_line,
  output logic sda_line
);
  // both lines have pull-ups, so a released line reads high
  initial begin
    scl_line = 1'b1;
    sda_line = 1'b1;
  end
  // start, then keep the clock low: a stuck agent, slow on purpose
  task automatic start_hold();
    sda_line <= 1'b0;
    #100 scl_line <= 1'b0;
  endtask : start_hold
  // release the clock, then stop while the clock is high
  task automatic stop_frame();
    scl_line <= 1'b1;
    #100 sda_line <= 1'b1;
  endtask : stop_frame
endmodule : i2c_bus_agent

// ---- tb/i2c_watch_properties.sv ----
// concurrent checks on the register bus and bus-watch ports
`timescale 1ns/1ps
module i2c_watch_properties
  import i2c_watch_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic bus_busy
);
  logic [11:0] rd_addr_q; // address of the read in flight
  logic mapped; // that address names a register
  // keep the read address so the answer can be judged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_q <= 12'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  assign mapped = (rd_addr_q inside {[12'h800:12'h818]}) && (rd_addr_q[1:0] == 2'h0);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_resp_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_data_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  unmapped_err_a: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  clear_reads_zero_a: assert property (s_axi_rvalid && rd_addr_q == OFF_ENABLE_CLEAR |-> s_axi_rdata == 32'h0)
    else $error("clear register holds state");
  limit_nibble_a: assert property (s_axi_rvalid && rd_addr_q == OFF_WATCH_LIMIT |-> s_axi_rdata[3:0] == 4'hf)
    else $error("limit low bits not ones");
  busy_start_a: assert property ($fell(sda_in) && scl_in |-> ##[1:8] bus_busy)
    else $error("start not seen");
endmodule : i2c_watch_properties

bind i2c_watch_top i2c_watch_properties u_props (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in, .sda_in, .bus_busy);

// ---- tb/i2c_watch_top_tb.sv ----
// self-checking bench for the two-wire support block
`timescale 1ns/1ps
module i2c_watch_top_tb;
  import i2c_watch_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, source_events = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf; // whole-word writes only
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, got, exp_en, cnt;
  logic scl_in, sda_in, function_tick, bus_busy, irq;
  int errors = 0;
  int n_compared = 0;
  int clr_pos[11] = '{0, 4, 6, 8, 11, 15, 16, 17, 19, 24, 25}; // every defined enable
  int div_set[2] = '{3, 0}; // divider ends at one for the watchdog
  always #2.5 sys_clk = ~sys_clk;
  i2c_watch_top u_dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in,
    .sda_in, .source_events, .function_tick, .bus_busy, .irq);
  i2c_bus_agent u_agent (.scl_line(scl_in), .sda_line(sda_in));
  // the only place the run ends
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // case equality, so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check
  // a handshake that never came ends the run
  task automatic give_up(input logic ok);
    if (!ok) begin
      errors++;
      $display("Error at %0t: no handshake", $time);
      print_verdict();
    end
  endtask : give_up
  // address and data offered together, each held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready && s_axi_wready) break;
    end
    give_up(n < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_bvalid) break;
    end
    give_up(n < 50);
    s_axi_bready <= 1'b1; // late ready exercises the held answer
    @(posedge sys_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check(32'(resp), 32'(RESP_OKAY));
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) break;
    end
    give_up(n < 50);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_rvalid) break;
    end
    give_up(n < 50);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    rd(a);
    check(got, want);
    check(32'(resp), 32'(RESP_OKAY));
  endtask : rd_chk
  // one-cycle engine event, then time for the flag and the interrupt
  task automatic pulse(input logic [31:0] v);
    source_events <= v;
    @(posedge sys_clk);
    source_events <= 32'h0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(OFF_ENABLE_SET, 32'h0);
    rd_chk(OFF_WATCH_LIMIT, 32'h0000_ffff);
    rd_chk(OFF_CLOCK_DIVIDER, 32'h0);
    rd_chk(OFF_ENABLE_CLEAR, 32'h0);
    rd(12'h81c);
    check(32'(resp), 32'(RESP_SLVERR));
    // knock enables out one at a time
    wr(OFF_ENABLE_SET, DEFINED_BITS);
    wr(OFF_ENABLE_CLEAR, 32'h0);
    rd_chk(OFF_ENABLE_SET, DEFINED_BITS);
    exp_en = DEFINED_BITS;
    foreach (clr_pos[i]) begin
      exp_en[clr_pos[i]] = 1'b0;
      wr(OFF_ENABLE_CLEAR, 32'h1 << clr_pos[i]);
      rd_chk(OFF_ENABLE_SET, exp_en);
    end
    // masked event stays quiet, enabled one raises the line
    wr(OFF_ENABLE_SET, 32'h1);
    pulse(32'h10);
    check(32'(irq), 32'h0);
    pulse(32'h1);
    check(32'(irq), 32'h1);
    rd_chk(OFF_FLAG_VIEW, 32'h1);
    rd_chk(OFF_FLAG_STATUS, 32'h11);
    check(32'(irq), 32'h0);
    // tick rate follows the divider
    foreach (div_set[i]) begin
      wr(OFF_CLOCK_DIVIDER, 32'(div_set[i]));
      cnt = 32'h0;
      repeat (40) begin
        @(posedge sys_clk);
        cnt = cnt + 32'(function_tick);
      end
      check(cnt, 32'(40 / (div_set[i] + 1)));
    end
    // smallest limit, written while both checks are still off
    wr(OFF_WATCH_LIMIT, 32'h0);
    rd_chk(OFF_WATCH_LIMIT, 32'h0000_000f);
    wr(OFF_WATCH_CTRL, 32'h3);
    wr(OFF_ENABLE_SET, 32'h0300_0000);
    u_agent.start_hold();
    repeat (60) @(posedge sys_clk);
    check(32'(bus_busy), 32'h1);
    check(32'(irq), 32'h1);
    wr(OFF_ENABLE_CLEAR, 32'h0300_0000);
    check(32'(irq), 32'h0);
    rd_chk(OFF_FLAG_VIEW, 32'h0);
    rd_chk(OFF_FLAG_STATUS, 32'h0300_0000);
    repeat (40) @(posedge sys_clk);
    check(32'(irq), 32'h0);
    u_agent.stop_frame();
    repeat (20) @(posedge sys_clk);
    check(32'(bus_busy), 32'h0);
    print_verdict();
  end
endmodule : i2c_watch_top_tb
